// File: core/dspg_map.vh
`ifndef DSPG_MAP_VH
`define DSPG_MAP_VH
`define DSPG_OFF_RUN_CFG 12'h060
`define DSPG_OFF_RUN_EN 12'h108
`define DSPG_OFF_SLEEP_EN 12'h118
`define DSPG_OFF_DEEP_EN 12'h128
`define DSPG_OFF_MODE 12'h200
`define DSPG_RESET_EN 8'h00
`define DSPG_RESET_CFG 1'h0
`define DSPG_ACG_BIT 11
`define DSPG_NPORT 8
`define DSPG_MODE_RUN 2'h0
`define DSPG_MODE_SLEEP 2'h1
`define DSPG_MODE_DEEP 2'h2
`endif

// File: core/dspg_port_gate.v
`include "dspg_map.vh"
module dspg_port_gate (
    input wire [1:0] mode,
    input wire auto_gate,
    input wire [7:0] run_en,
    input wire [7:0] sleep_en,
    input wire [7:0] deep_en,
    output wire [7:0] port_en
);
    genvar i;
    generate
        for (i = 0; i < `DSPG_NPORT; i = i + 1) begin : g_bit
            // Each bit stands alone; sleep registers apply only with auto gating
            assign port_en[i] = (!auto_gate || mode == `DSPG_MODE_RUN) ? run_en[i] :
                (mode == `DSPG_MODE_DEEP) ? deep_en[i] : sleep_en[i];
        end
    endgenerate
endmodule

// File: core/dspg_clock_gate.v
// Decided for this implementation: the Avalon-MM register port.
`include "dspg_map.vh"
module dspg_clock_gate (
    input wire ref_clk,
    input wire srst,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire [1:0] avs_response,
    input wire deep_sleep_req,
    input wire sleep_req,
    input wire wake,
    input wire [2:0] port_sel,
    input wire port_access,
    output wire [7:0] port_clk_en,
    output wire port_bus_fault,
    output wire [1:0] power_mode
);
    ////////////////////////////////////////////////////////////////////////
    reg [7:0] run_en_reg;
    reg [7:0] sleep_en_reg;
    reg [7:0] deep_en_reg;
    reg auto_gate_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg ack_reg;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    reg [1:0] resp_reg;
    reg [1:0] resp_next;
    reg fault_reg;
    reg fault_next;
    wire req;
    wire take;
    wire wr_lo;
    wire wr_hi;
    wire sel_run_cfg;
    wire sel_run_en;
    wire sel_sleep_en;
    wire sel_deep_en;
    wire sel_mode;
    wire hit;
    wire wr_run_cfg;
    wire wr_run_en;
    wire wr_sleep_en;
    wire wr_deep_en;
    wire port_gated;

    ////////////////////////////////////////////////////////////////////////
    // One wait state: the answer comes on the second edge of the request
    assign req = (avs_read || avs_write) && !ack_reg;
    assign take = (avs_read || avs_write) && ack_reg;
    assign avs_waitrequest = req;
    assign avs_readdata = rdata_reg;
    assign avs_response = resp_reg;
    assign power_mode = mode_reg;
    assign port_bus_fault = fault_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign sel_run_cfg = avs_address == `DSPG_OFF_RUN_CFG;
    assign sel_run_en = avs_address == `DSPG_OFF_RUN_EN;
    assign sel_sleep_en = avs_address == `DSPG_OFF_SLEEP_EN;
    assign sel_deep_en = avs_address == `DSPG_OFF_DEEP_EN;
    assign sel_mode = avs_address == `DSPG_OFF_MODE;
    assign hit = sel_run_cfg || sel_run_en || sel_sleep_en ||
        sel_deep_en || sel_mode;

    // Writes land on the edge that completes the transfer
    assign wr_lo = avs_write && take && avs_byteenable[0];
    assign wr_hi = avs_write && take && avs_byteenable[1];
    assign wr_run_cfg = wr_hi && sel_run_cfg;
    assign wr_run_en = wr_lo && sel_run_en;
    assign wr_sleep_en = wr_lo && sel_sleep_en;
    assign wr_deep_en = wr_lo && sel_deep_en;

    ////////////////////////////////////////////////////////////////////////
    // Read data and response for the addressed register
    always @* begin
        rdata_next = 32'h0000_0000;
        // Unmapped addresses answer with a slave error and read zero
        resp_next = hit ? 2'h0 : 2'h2;
        // Reserved bits above the enables always read as zero
        case (avs_address)
            `DSPG_OFF_RUN_CFG: begin
                rdata_next = {20'h0_0000, auto_gate_reg, 11'h0};
            end
            `DSPG_OFF_RUN_EN: begin
                rdata_next = {24'h00_0000, run_en_reg};
            end
            `DSPG_OFF_SLEEP_EN: begin
                rdata_next = {24'h00_0000, sleep_en_reg};
            end
            `DSPG_OFF_DEEP_EN: begin
                rdata_next = {24'h00_0000, deep_en_reg};
            end
            `DSPG_OFF_MODE: begin
                rdata_next = {30'h0, mode_reg};
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            resp_reg <= 2'h0;
        end else begin
            ack_reg <= req;
            // Captured in the wait cycle; stands until the next access
            if (req) begin
                rdata_reg <= rdata_next;
                resp_reg <= resp_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable registers: only the low lane holds enables
    // The auto gating bit sits in the second lane of the run configuration
    always @(posedge ref_clk) begin
        if (srst) begin
            run_en_reg <= `DSPG_RESET_EN;
            sleep_en_reg <= `DSPG_RESET_EN;
            deep_en_reg <= `DSPG_RESET_EN;
            auto_gate_reg <= `DSPG_RESET_CFG;
        end else begin
            if (wr_run_en) begin
                run_en_reg <= avs_writedata[7:0];
            end
            if (wr_sleep_en) begin
                sleep_en_reg <= avs_writedata[7:0];
            end
            if (wr_deep_en) begin
                deep_en_reg <= avs_writedata[7:0];
            end
            if (wr_run_cfg) begin
                auto_gate_reg <= avs_writedata[`DSPG_ACG_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode: deep sleep has priority over sleep; in run, a sleep request is taken even with wake high
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            `DSPG_MODE_RUN: begin
                if (deep_sleep_req) begin
                    mode_next = `DSPG_MODE_DEEP;
                end else if (sleep_req) begin
                    mode_next = `DSPG_MODE_SLEEP;
                end
            end
            `DSPG_MODE_SLEEP: begin
                if (wake) begin
                    mode_next = `DSPG_MODE_RUN;
                end
            end
            `DSPG_MODE_DEEP: begin
                if (wake) begin
                    mode_next = `DSPG_MODE_RUN;
                end
            end
            default: begin
                mode_next = `DSPG_MODE_RUN;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            mode_reg <= `DSPG_MODE_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port clocks follow the register of the current power mode with auto gating on; with it off, the run register in every mode
    dspg_port_gate u_gate (
        .mode(mode_reg),
        .auto_gate(auto_gate_reg),
        .run_en(run_en_reg),
        .sleep_en(sleep_en_reg),
        .deep_en(deep_en_reg),
        .port_en(port_clk_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access to an unclocked port faults one cycle later, for as long as the access lasts
    assign port_gated = !port_clk_en[port_sel];

    always @* begin
        fault_next = port_access && port_gated;
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
        end
    end
endmodule

// File: tb/dspg_clock_gate_sva.sv
module dspg_clock_gate_sva (
    input wire ref_clk,
    input wire srst,
    input wire avs_read,
    input wire avs_write,
    input wire [11:0] avs_address,
    input wire avs_waitrequest,
    input wire [1:0] avs_response,
    input wire [31:0] avs_readdata,
    input wire deep_sleep_req,
    input wire wake,
    input wire [2:0] port_sel,
    input wire port_access,
    input wire [7:0] port_clk_en,
    input wire port_bus_fault,
    input wire [1:0] power_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire req = avs_read | avs_write;
    sequence s_wait; req && avs_waitrequest; endsequence
    sequence s_take; req && !avs_waitrequest; endsequence
    a_wait_first: assert property ($rose(req) |-> s_wait) else $error("no wait state");
    a_wait_one: assert property (s_wait |=> s_take) else $error("wait too long");
    a_unmapped_err: assert property (s_wait ##1 (s_take and avs_address == 12'hffc) |->
        avs_response == 2'h2 && avs_readdata == 32'h0) else $error("bad unmapped answer");
    a_resvd_zero: assert property ((s_take and avs_read && avs_address == 12'h128) |->
        avs_readdata[31:8] == 24'h0) else $error("reserved bits set");
    a_fault_gated: assert property (port_access && !port_clk_en[port_sel] |=>
        port_bus_fault) else $error("missing fault");
    a_fault_cause: assert property (port_bus_fault |->
        $past(port_access && !port_clk_en[port_sel])) else $error("spurious fault");
    a_reset_clear: assert property (disable iff (1'b0) srst |=>
        port_clk_en == 8'h00 && power_mode == 2'h0) else $error("reset not clear");
    a_deep_entry: assert property (power_mode == 2'h0 && deep_sleep_req |=>
        power_mode == 2'h2) else $error("no deep entry");
    a_wake_run: assert property (power_mode != 2'h0 && wake |=>
        power_mode == 2'h0) else $error("no wake");
endmodule
bind dspg_clock_gate dspg_clock_gate_sva u_sva (
    .ref_clk(ref_clk),
    .srst(srst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_address(avs_address),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response),
    .avs_readdata(avs_readdata),
    .deep_sleep_req(deep_sleep_req),
    .wake(wake),
    .port_sel(port_sel),
    .port_access(port_access),
    .port_clk_en(port_clk_en),
    .port_bus_fault(port_bus_fault),
    .power_mode(power_mode)
);

// File: tb/dspg_clock_gate_test.sv
module dspg_clock_gate_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, srst = 1, avs_read = 0, avs_write = 0, deep_sleep_req = 0;
    logic sleep_req = 0, wake = 0, port_access = 0;
    logic [11:0] avs_address = 12'h0;
    logic [31:0] avs_writedata = 32'h0, rdata;
    logic [2:0] port_sel = 3'h0;
    logic [1:0] resp;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, port_bus_fault;
    wire [1:0] avs_response, power_mode;
    wire [7:0] port_clk_en;
    logic [3:0] avs_byteenable = 4'hf;
    int n_mismatch = 0, comparisons = 0;
    dspg_clock_gate dut (
        .ref_clk(ref_clk),
        .srst(srst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response),
        .deep_sleep_req(deep_sleep_req),
        .sleep_req(sleep_req),
        .wake(wake),
        .port_sel(port_sel),
        .port_access(port_access),
        .port_clk_en(port_clk_en),
        .port_bus_fault(port_bus_fault),
        .power_mode(power_mode)
    );
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rdata = avs_readdata;
        resp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Pulse one power request: 0 wake, 1 sleep, 2 deep-sleep
    task mode(input int m);
        @(posedge ref_clk);
        wake <= m == 0;
        sleep_req <= m == 1;
        deep_sleep_req <= m == 2;
        @(posedge ref_clk);
        {wake, sleep_req, deep_sleep_req} <= 3'h0;
        @(negedge ref_clk);
    endtask
    task poke(input logic [2:0] p, input logic exp);
        @(posedge ref_clk);
        port_access <= 1'b1;
        port_sel <= p;
        @(posedge ref_clk);
        port_access <= 1'b0;
        @(negedge ref_clk);
        chk({31'h0, port_bus_fault}, {31'h0, exp});
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        chk({24'h0, port_clk_en}, 32'h0);
        acc(1'b0, 12'h128, 32'h0);
        chk(rdata, 32'h0);
        acc(1'b1, 12'h128, 32'hffffffa5);
        acc(1'b0, 12'h128, 32'h0);
        chk(rdata, 32'ha5);
        chk({30'h0, resp}, 32'h0);
        acc(1'b0, 12'h108, 32'h0);
        chk(rdata, 32'h0);
        acc(1'b1, 12'h108, {rdata[31:8], 8'h0f});
        acc(1'b1, 12'h118, 32'h3c);
        acc(1'b1, 12'h060, 32'h800);
        @(negedge ref_clk);
        chk({24'h0, port_clk_en}, 32'h0f);
        mode(2);
        chk({24'h0, port_clk_en}, 32'ha5);
        chk({30'h0, power_mode}, 32'h2);
        poke(3'h1, 1'b1);
        poke(3'h0, 1'b0);
        acc(1'b0, 12'h200, 32'h0);
        chk(rdata, 32'h2);
        mode(0);
        chk({24'h0, port_clk_en}, 32'h0f);
        mode(1);
        chk({24'h0, port_clk_en}, 32'h3c);
        mode(0);
        acc(1'b1, 12'h060, 32'h0);
        mode(2);
        chk({24'h0, port_clk_en}, 32'h0f);
        mode(0);
        acc(1'b0, 12'hffc, 32'h0);
        chk({30'h0, resp}, 32'h2);
        complete_run;
    end
    initial begin
        #20000;
        n_mismatch++;
        complete_run;
    end
endmodule
